// *** verilog/ssm_map.svh ***
// Offsets, field positions, reset values and timing counts of the serial config block
`ifndef SSM_MAP_SVH
`define SSM_MAP_SVH

// ---------------------------------------------------------------
// Serial word layout
// ---------------------------------------------------------------
`define SSM_WORD_BITS        26
`define SSM_HOLD_BITS        24
`define SSM_SEL_MSB          1
`define SSM_HOLD_LSB         2

// ---------------------------------------------------------------
// Hold register select codes
// ---------------------------------------------------------------
`define SSM_SEL_OPERATION    2'h0
`define SSM_SEL_AUTO_CAL     2'h1
`define SSM_SEL_FREQ_ONE     2'h2
`define SSM_SEL_FREQ_TWO     2'h3

// ---------------------------------------------------------------
// Operation-mode field positions (word bit numbering)
// ---------------------------------------------------------------
`define SSM_PUMP_CUR_MSB     4
`define SSM_PUMP_CUR_LSB     2
`define SSM_PUMP_DLY_MSB     6
`define SSM_PUMP_DLY_LSB     5
`define SSM_POLARITY_BIT     7
`define SSM_FLOAT_BIT        8
`define SSM_SUPPLY_MSB       12
`define SSM_SUPPLY_LSB       10
`define SSM_REF_BW_MSB       14
`define SSM_REF_BW_LSB       13
`define SSM_DIAG_MSB         17
`define SSM_DIAG_LSB         15
`define SSM_PRE_BIAS_MSB     22
`define SSM_PRE_BIAS_LSB     21
`define SSM_PRE_MODE_BIT     23

// Tuning-loop enable in the auto calibration word
`define SSM_TUNE_EN_BIT      20

// ---------------------------------------------------------------
// Diagnostic output select codes
// ---------------------------------------------------------------
`define SSM_DIAG_LOCK        3'h0
`define SSM_DIAG_REF_DIV     3'h1
`define SSM_DIAG_FB_DIV      3'h2
`define SSM_DIAG_TUNE_TEST   3'h7

// ---------------------------------------------------------------
// Reset values and timing
// ---------------------------------------------------------------
`define SSM_HOLD_RESET       24'h000000
`define SSM_COARSE_BITS      7
`define SSM_COARSE_MID       7'h40
`define SSM_CLK_PERIOD_NS    25
`define SSM_SETTLE_NS        1000
`define SSM_SETTLE_CYCLES    ((`SSM_SETTLE_NS + `SSM_CLK_PERIOD_NS - 1) / `SSM_CLK_PERIOD_NS)

`endif

// *** verilog/ssm_pkg.sv ***
// Types shared by the serial configuration block
`default_nettype none
package ssm_pkg;

    // Auto-tune sequencer states
    typedef enum logic [1:0] {
        SSM_TUNE_IDLE,
        SSM_TUNE_SETTLE,
        SSM_TUNE_DECIDE,
        SSM_TUNE_FINE
    } ssm_tune_e;

    // Decoded operation-mode controls
    typedef struct packed {
        logic [2:0] pump_current_select;
        logic [1:0] pump_delay_select;
        logic       detector_polarity;
        logic       pump_output_float;
        logic       modulator_supply_control;
        logic       divider_supply_control;
        logic       loop_supply_control;
        logic [1:0] reference_buffer_bandwidth;
        logic [2:0] diag_select;
        logic [1:0] prescaler_bias;
        logic       prescaler_mode;
    } ssm_opmode_s;

    // Auto-tune status
    typedef struct packed {
        logic [6:0] coarse_code;
        logic       busy;
        logic       fine_tune_en;
    } ssm_tune_s;

endpackage
`default_nettype wire

// *** verilog/ssm_serial_config.sv ***
// Three-wire serial configuration port, hold registers and auto-tune sequencer
`include "ssm_map.svh"
`default_nettype none

module ssm_serial_config #(
    parameter int SETTLE_CYCLES = `SSM_SETTLE_CYCLES
) (
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    input  wire logic                 serial_clock,
    input  wire logic                 serial_data,
    input  wire logic                 latch_strobe,
    input  wire logic                 vco_above_target,
    input  wire logic                 lock_detect,
    input  wire logic                 ref_divider_out,
    input  wire logic                 fb_divider_out,
    output var  ssm_pkg::ssm_opmode_s opmode,
    output var  ssm_pkg::ssm_tune_s   tune,
    output logic [23:0]               auto_calibration_control,
    output logic [23:0]               frequency_control_one,
    output logic [23:0]               frequency_control_two,
    output logic                      lock_indicator_pin
);
    import ssm_pkg::*;

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    logic [3:0] sync_a_r;
    logic [3:0] sync_b_r;
    logic       sclk_prev_r;
    logic       strobe_prev_r;
    logic       sclk_s;
    logic       data_s;
    logic       strobe_s;
    logic       above_s;

    // Two flops on the serial, strobe and comparator pins before any logic looks at them
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sync_a_r <= 4'h0;
            sync_b_r <= 4'h0;
        end else begin
            sync_a_r <= {vco_above_target, latch_strobe,
                         serial_data, serial_clock};
            sync_b_r <= sync_a_r;
        end
    end

    assign sclk_s   = sync_b_r[0];
    assign data_s   = sync_b_r[1];
    assign strobe_s = sync_b_r[2];
    assign above_s  = sync_b_r[3];

    // Previous values for edge detection
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sclk_prev_r   <= 1'b0;
            strobe_prev_r <= 1'b0;
        end else begin
            sclk_prev_r   <= sclk_s;
            strobe_prev_r <= strobe_s;
        end
    end

    logic sclk_rise;
    logic strobe_fall;

    // Clock gated by the strobe: edges while it is high are dropped
    assign sclk_rise   = sclk_s & ~sclk_prev_r & ~strobe_s;
    assign strobe_fall = ~strobe_s & strobe_prev_r;

    // ---------------------------------------------------------------
    // Load register
    // ---------------------------------------------------------------
    logic [`SSM_WORD_BITS-1:0] load_r;

    // MSB first: new bit enters at the bottom and moves up
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            load_r <= '0;
        end else if (sclk_rise) begin
            load_r <= {load_r[`SSM_WORD_BITS-2:0], data_s};
        end
    end

    // ---------------------------------------------------------------
    // Hold registers
    // ---------------------------------------------------------------
    logic [1:0]  sel;
    logic [23:0] hold_data;
    logic [23:0] operation_mode_r;
    logic [23:0] auto_cal_r;
    logic [23:0] freq_one_r;
    logic [23:0] freq_two_r;
    logic        freq_write;

    assign sel       = load_r[`SSM_SEL_MSB:0];
    assign hold_data = load_r[`SSM_WORD_BITS-1:`SSM_HOLD_LSB];

    // Latch on strobe fall; unaddressed registers keep their value
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            operation_mode_r <= `SSM_HOLD_RESET;
            auto_cal_r       <= `SSM_HOLD_RESET;
            freq_one_r       <= `SSM_HOLD_RESET;
            freq_two_r       <= `SSM_HOLD_RESET;
        end else if (strobe_fall) begin
            case (sel)
                `SSM_SEL_OPERATION: operation_mode_r <= hold_data;
                `SSM_SEL_AUTO_CAL:  auto_cal_r       <= hold_data;
                `SSM_SEL_FREQ_ONE:  freq_one_r       <= hold_data;
                `SSM_SEL_FREQ_TWO:  freq_two_r       <= hold_data;
                default:            operation_mode_r <= operation_mode_r;
            endcase
        end
    end

    assign freq_write = strobe_fall & sel[`SSM_SEL_MSB];

    assign auto_calibration_control = auto_cal_r;
    assign frequency_control_one    = freq_one_r;
    assign frequency_control_two    = freq_two_r;

    // ---------------------------------------------------------------
    // Operation-mode decode (hold bit = word bit - 2)
    // ---------------------------------------------------------------
    localparam int H = `SSM_HOLD_LSB;

    // Fields go straight out of the hold register flops
    always_comb begin
        opmode.pump_current_select =
            operation_mode_r[`SSM_PUMP_CUR_MSB-H:`SSM_PUMP_CUR_LSB-H];
        opmode.pump_delay_select =
            operation_mode_r[`SSM_PUMP_DLY_MSB-H:`SSM_PUMP_DLY_LSB-H];
        opmode.detector_polarity =
            operation_mode_r[`SSM_POLARITY_BIT-H];
        opmode.pump_output_float =
            operation_mode_r[`SSM_FLOAT_BIT-H];
        opmode.modulator_supply_control =
            operation_mode_r[`SSM_SUPPLY_LSB-H];
        opmode.divider_supply_control =
            operation_mode_r[`SSM_SUPPLY_LSB+1-H];
        opmode.loop_supply_control =
            operation_mode_r[`SSM_SUPPLY_MSB-H];
        opmode.reference_buffer_bandwidth =
            operation_mode_r[`SSM_REF_BW_MSB-H:`SSM_REF_BW_LSB-H];
        opmode.diag_select =
            operation_mode_r[`SSM_DIAG_MSB-H:`SSM_DIAG_LSB-H];
        opmode.prescaler_bias =
            operation_mode_r[`SSM_PRE_BIAS_MSB-H:`SSM_PRE_BIAS_LSB-H];
        opmode.prescaler_mode =
            operation_mode_r[`SSM_PRE_MODE_BIT-H];
    end

    // ---------------------------------------------------------------
    // Auto-tune sequencer
    // ---------------------------------------------------------------
    ssm_tune_e   state_r;
    logic [6:0]  coarse_r;
    logic [6:0]  trial_r;
    logic [2:0]  step_r;
    logic [15:0] wait_r;
    logic        arm_r;
    logic        enable_prev_r;
    logic        enable;
    logic        start;

    assign enable = auto_cal_r[`SSM_TUNE_EN_BIT-H];
    // Start needs a fresh 0 to 1 edge of the tuning-loop enable
    assign start  = arm_r & enable & ~enable_prev_r;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            enable_prev_r <= 1'b0;
        end else begin
            enable_prev_r <= enable;
        end
    end

    // Armed by reset and by each frequency word; arming wins over start;
    // a start refused while busy leaves the arm standing
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            arm_r <= 1'b1;
        end else if (freq_write) begin
            arm_r <= 1'b1;
        end else if (start && !tune.busy) begin
            arm_r <= 1'b0;
        end
    end

    // Seven trial bits, MSB first, each after a settle wait
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_r  <= SSM_TUNE_IDLE;
            coarse_r <= `SSM_COARSE_MID;
            trial_r  <= `SSM_COARSE_MID;
            step_r   <= 3'h0;
            wait_r   <= 16'h0000;
        end else begin
            case (state_r)
                SSM_TUNE_IDLE, SSM_TUNE_FINE: begin
                    if (start) begin
                        state_r  <= SSM_TUNE_SETTLE;
                        coarse_r <= `SSM_COARSE_MID;
                        trial_r  <= `SSM_COARSE_MID;
                        step_r   <= 3'h0;
                        wait_r   <= 16'(SETTLE_CYCLES - 1);
                    end
                end
                SSM_TUNE_SETTLE: begin
                    if (wait_r == 16'h0000) begin
                        state_r <= SSM_TUNE_DECIDE;
                    end else begin
                        wait_r <= wait_r - 16'h0001;
                    end
                end
                SSM_TUNE_DECIDE: begin
                    // Too fast: drop the trial bit, keep it otherwise
                    if (above_s) begin
                        coarse_r <= coarse_r & ~trial_r;
                    end
                    if (step_r == 3'h6) begin
                        state_r <= SSM_TUNE_FINE;
                    end else begin
                        step_r   <= step_r + 3'h1;
                        trial_r  <= trial_r >> 1;
                        coarse_r <= (above_s ? (coarse_r & ~trial_r)
                                             : coarse_r) | (trial_r >> 1);
                        wait_r   <= 16'(SETTLE_CYCLES - 1);
                        state_r  <= SSM_TUNE_SETTLE;
                    end
                end
                default: state_r <= SSM_TUNE_IDLE;
            endcase
        end
    end

    always_comb begin
        tune.coarse_code  = coarse_r;
        tune.busy         = (state_r == SSM_TUNE_SETTLE) ||
                            (state_r == SSM_TUNE_DECIDE);
        tune.fine_tune_en = (state_r == SSM_TUNE_FINE);
    end

    // ---------------------------------------------------------------
    // Lock indicator pin mux
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            lock_indicator_pin <= 1'b0;
        end else begin
            case (opmode.diag_select)
                `SSM_DIAG_LOCK:      lock_indicator_pin <= lock_detect;
                `SSM_DIAG_REF_DIV:   lock_indicator_pin <= ref_divider_out;
                `SSM_DIAG_FB_DIV:    lock_indicator_pin <= fb_divider_out;
                `SSM_DIAG_TUNE_TEST: lock_indicator_pin <= tune.busy;
                default:             lock_indicator_pin <= 1'b0;
            endcase
        end
    end

endmodule
`default_nettype wire

// *** tb/ssm_serial_config_sva.sv ***
// Assertion checker for the serial configuration block
`default_nettype none
module ssm_serial_config_sva #(
    parameter int SETTLE_CYCLES = 40
) (
    input wire logic                 clk,
    input wire logic                 rst_b,
    input wire logic                 serial_clock,
    input wire logic                 serial_data,
    input wire logic                 latch_strobe,
    input wire logic                 vco_above_target,
    input wire logic                 lock_detect,
    input wire logic                 ref_divider_out,
    input wire logic                 fb_divider_out,
    input wire ssm_pkg::ssm_opmode_s opmode,
    input wire ssm_pkg::ssm_tune_s   tune,
    input wire logic [23:0]          auto_calibration_control,
    input wire logic [23:0]          frequency_control_one,
    input wire logic [23:0]          frequency_control_two,
    input wire logic                 lock_indicator_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    import ssm_pkg::*;

    // Lock pin carries lock detect one cycle later
    property p_pin_lock;
        @(posedge clk) disable iff (!rst_b)
        $past(rst_b) && $past(opmode.diag_select) == 3'h0
            |-> lock_indicator_pin == $past(lock_detect);
    endproperty
    a_pin_lock: assert property (p_pin_lock)
        else $error("lock pin does not follow lock detect");

    // Tune test code shows the search activity
    property p_pin_test;
        @(posedge clk) disable iff (!rst_b)
        $past(rst_b) && $past(opmode.diag_select) == 3'h7
            |-> lock_indicator_pin == $past(tune.busy);
    endproperty
    a_pin_test: assert property (p_pin_test)
        else $error("lock pin does not follow tune test");

    // Unused codes hold the pin low
    property p_pin_unused;
        @(posedge clk) disable iff (!rst_b)
        $past(rst_b) && $past(opmode.diag_select) inside {[3'h3:3'h6]}
            |-> !lock_indicator_pin;
    endproperty
    a_pin_unused: assert property (p_pin_unused)
        else $error("lock pin active on unused code");

    // A change of frequency word one leaves frequency word two and auto cal alone
    property p_one_hold;
        @(posedge clk) disable iff (!rst_b)
        $changed(frequency_control_one) |-> $stable(frequency_control_two)
            && $stable(auto_calibration_control);
    endproperty
    a_one_hold: assert property (p_one_hold)
        else $error("two hold registers changed together");

    // Search starts from the midpoint code
    property p_start_mid;
        @(posedge clk) disable iff (!rst_b)
        $rose(tune.busy) |-> tune.coarse_code == 7'h40;
    endproperty
    a_start_mid: assert property (p_start_mid)
        else $error("search did not start at midpoint");

    // Seven steps keep the search busy for a while
    property p_search_len;
        @(posedge clk) disable iff (!rst_b)
        $rose(tune.busy) |-> tune.busy [*8];
    endproperty
    a_search_len: assert property (p_search_len)
        else $error("search ended too early");

    // Search hands over to fine tuning in bounded time
    property p_search_ends;
        @(posedge clk) disable iff (!rst_b)
        $rose(tune.busy) |-> ##[8:1000] tune.fine_tune_en;
    endproperty
    a_search_ends: assert property (p_search_ends)
        else $error("fine tuning never started");

    // Coarse code frozen during fine tuning
    property p_fine_hold;
        @(posedge clk) disable iff (!rst_b)
        tune.fine_tune_en && $past(tune.fine_tune_en)
            |-> $stable(tune.coarse_code) && !tune.busy;
    endproperty
    a_fine_hold: assert property (p_fine_hold)
        else $error("coarse code moved in fine tuning");

    // Reset leaves midpoint code, idle search and cleared fields
    property p_reset;
        @(posedge clk)
        !rst_b |=> tune.coarse_code == 7'h40 && !tune.busy
            && !tune.fine_tune_en && opmode == '0;
    endproperty
    a_reset: assert property (p_reset)
        else $error("wrong state after reset");
endmodule

bind ssm_serial_config ssm_serial_config_sva #(
    .SETTLE_CYCLES(SETTLE_CYCLES)
) u_sva (
    .clk, .rst_b, .serial_clock, .serial_data, .latch_strobe,
    .vco_above_target, .lock_detect, .ref_divider_out, .fb_divider_out,
    .opmode, .tune, .auto_calibration_control, .frequency_control_one,
    .frequency_control_two, .lock_indicator_pin
);
`default_nettype wire

// *** tb/ssm_host_model.sv ***
// Host controller model driving the three-wire serial port
`default_nettype none
module ssm_host_model (
    input  wire logic clk,
    output var  logic serial_clock,
    output var  logic serial_data,
    output var  logic latch_strobe
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus: clock still, strobe high until first word
    initial begin
        serial_clock = 1'b0;
        serial_data = 1'b0;
        latch_strobe = 1'b1;
    end

    // Each phase spans three system clocks so the sync sees it
    task automatic send_word(input logic [25:0] w);
        latch_strobe = 1'b0;
        repeat (3) @(negedge clk);
        for (int i = 25; i >= 0; i--) begin
            serial_data = w[i];
            repeat (3) @(negedge clk);
            serial_clock = 1'b1;
            repeat (3) @(negedge clk);
            serial_clock = 1'b0;
        end
        serial_data = ~w[0];
        repeat (3) @(negedge clk);
        latch_strobe = 1'b1;
        repeat (3) @(negedge clk);
        latch_strobe = 1'b0;
        repeat (6) @(negedge clk);
    endtask

    // Clock pulses with the strobe high, then a fresh fall
    task automatic blocked_clocks();
        latch_strobe = 1'b1;
        serial_data = 1'b1;
        repeat (26) begin
            repeat (3) @(negedge clk);
            serial_clock = 1'b1;
            repeat (3) @(negedge clk);
            serial_clock = 1'b0;
        end
        latch_strobe = 1'b0;
        repeat (6) @(negedge clk);
    endtask
endmodule
`default_nettype wire

// *** tb/test_synth_serial_mode_config.sv ***
// Testbench for the serial configuration block
`default_nettype none
module test_synth_serial_mode_config
    import ssm_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    localparam int SETTLE = 6;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        serial_clock, serial_data, latch_strobe;
    logic        vco_above_target = 1'b0;
    logic        lock_detect = 1'b0;
    logic        ref_divider_out = 1'b0;
    logic        fb_divider_out = 1'b0;
    ssm_opmode_s opmode;
    ssm_tune_s   tune;
    logic [23:0] auto_cal, freq_one, freq_two;
    logic        lock_pin;
    logic [6:0]  target = 7'h2B;
    logic        pin_busy = 1'b0;
    logic [2:0]  diag_tab [8] = '{3'h0, 3'h1, 3'h2, 3'h7,
                                  3'h3, 3'h4, 3'h5, 3'h6};
    int          errors = 0;
    int          n_tests = 0;

    // Clock and oscillator comparator model
    initial forever #12.5 clk = ~clk;
    always @(negedge clk) vco_above_target <= tune.coarse_code > target;

    ssm_host_model host (
        .clk          (clk),
        .serial_clock (serial_clock),
        .serial_data  (serial_data),
        .latch_strobe (latch_strobe)
    );

    ssm_serial_config #(.SETTLE_CYCLES(SETTLE)) dut (
        .clk                      (clk),
        .rst_b                    (rst_b),
        .serial_clock             (serial_clock),
        .serial_data              (serial_data),
        .latch_strobe             (latch_strobe),
        .vco_above_target         (vco_above_target),
        .lock_detect              (lock_detect),
        .ref_divider_out          (ref_divider_out),
        .fb_divider_out           (fb_divider_out),
        .opmode                   (opmode),
        .tune                     (tune),
        .auto_calibration_control (auto_cal),
        .frequency_control_one    (freq_one),
        .frequency_control_two    (freq_two),
        .lock_indicator_pin       (lock_pin)
    );

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: %s seen %h", $time, what, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Bounded wait for busy or fine tuning
    task automatic wait_tune(input bit fine, input int limit);
        int n;
        n = 0;
        while ((fine ? tune.fine_tune_en : tune.busy) !== 1'b1) begin
            @(negedge clk);
            n++;
            if (n > limit) begin
                errors++;
                $display("mismatch at %0t: auto-tune wait ran out", $time);
                stop_test();
            end
        end
    endtask

    // Enable low then high, run the search to the given target
    task automatic tune_run(input logic [6:0] t);
        target = t;
        host.send_word(26'h0000001);
        host.send_word(26'h0100001);
        wait_tune(1'b0, 100);
        repeat (2) @(negedge clk);
        check(lock_pin, pin_busy, "pin during search");
        wait_tune(1'b1, 2000);
        check(tune.coarse_code, t, "coarse code");
        check(tune.busy, 1'b0, "busy after search");
    endtask

    initial begin
        logic [25:0] w;
        logic        exp_pin;
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        check(tune, {7'h40, 2'b00}, "tune at reset");
        check(auto_cal | freq_one | freq_two, 0, "holds");
        $display("test reset done");
        // Every pump current and diag code, delay, polarity and supply fixed, lock pin source per selection
        for (int i = 0; i < 8; i++) begin
            w = {2'b00, i[0], i[1:0], 3'b000, diag_tab[i], i[2:1], 3'b100,
                 1'b0, ~i[0], 3'b000, i[2:0], 2'b00};
            host.send_word(w);
            check(opmode.pump_delay_select, 2'b00, "delay");
            check(opmode.detector_polarity, 1'b0, "polarity");
            check({opmode.loop_supply_control, opmode.divider_supply_control,
                   opmode.modulator_supply_control}, 3'b100,
                  "supply");
            check(opmode, ssm_opmode_s'({w[4:2], w[6:5], w[7], w[8], w[10],
                  w[11], w[12], w[14:13], w[17:15], w[22:21], w[23]}),
                  "opmode");
            for (int k = 0; k < 2; k++) begin
                lock_detect = k[0];
                ref_divider_out = ~k[0];
                fb_divider_out = k[0];
                repeat (3) @(negedge clk);
                exp_pin = (diag_tab[i] == 3'h0) ? k[0] :
                          (diag_tab[i] == 3'h1) ? ~k[0] :
                          (diag_tab[i] == 3'h2) ? k[0] : 1'b0;
                check(lock_pin, exp_pin, "lock pin");
            end
        end
        $display("test opmode done");
        host.send_word({24'hA5C31E, 2'b10});
        check(freq_one, 24'hA5C31E, "freq one");
        check(freq_two, 24'h0, "freq two kept");
        host.send_word({24'h5A3CE1, 2'b11});
        check(freq_two, 24'h5A3CE1, "freq two");
        check(freq_one, 24'hA5C31E, "freq one kept");
        host.blocked_clocks();
        check(freq_two, 24'h5A3CE1, "strobe high shift");
        check(auto_cal, 24'h0, "auto cal kept");
        $display("test hold registers done");
        tune_run(7'h2B);
        host.send_word(26'h0000001);
        host.send_word(26'h0100001);
        repeat (20) @(negedge clk);
        check(tune.busy, 1'b0, "unarmed start");
        check(auto_cal, 24'h040000, "auto cal word");
        host.send_word({24'h13579B, 2'b10});
        tune_run(7'h61);
        host.send_word({24'h2468AC, 2'b11});
        tune_run(7'h7F);
        // Reset in fine tuning: only the reset arms the next search
        rst_b = 1'b0;
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        check(tune, {7'h40, 2'b00}, "tune after reset");
        check(opmode, 18'h0, "opmode after reset");
        host.send_word(26'h003F000);
        pin_busy = 1'b1;
        tune_run(7'h00);
        $display("test auto-tune done");
        stop_test();
    end
endmodule
`default_nettype wire
